// ===== verilog/tor_pkg.sv
`default_nettype none
package tor_pkg;
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_SYN_FREQ  = 8'h04;
  localparam logic [7:0]  REG_SMP_FREQ  = 8'h08;
  localparam logic [7:0]  REG_OFS_WORD  = 8'h0c;
  localparam logic [7:0]  REG_STATUS    = 8'h10;
  localparam int          CTRL_SERIAL   = 0;
  localparam int          CTRL_VPOL     = 1;
  localparam int          CTRL_SAMPLED  = 2;
  localparam int          CTRL_PSEL_LSB = 3;
  localparam int          CTRL_IDLE_LVL = 5;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0002;
  localparam logic [31:0] FREQ_RST      = 32'h0000_0000;
  localparam int          STAT_LVL_LSB  = 0;
  localparam int          STAT_PEND     = 8;
  localparam int          STAT_BUSY     = 9;
  localparam int          STAT_ST_LSB   = 12;
  localparam int          OUT_W         = 10;
  localparam int          NCO_W         = 32;
  localparam int          PH_W          = 5;
  localparam int          PH_TOP        = 8;
  localparam int          SER_HALF_CYC  = 2;
  localparam int          FIFO_DEPTH    = 16;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  typedef enum logic [1:0] {
    SER_IDLE  = 2'b00,
    SER_LEAD  = 2'b01,
    SER_SHIFT = 2'b10
  } tor_ser_e;
endpackage : tor_pkg
`default_nettype wire

// ===== verilog/tor_top.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tor_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = tor_pkg::FIFO_DEPTH
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];
  assign level     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : tor_fifo

module tor_top #(
  parameter int OFS_W    = tor_pkg::NCO_W,
  parameter int SER_HALF = tor_pkg::SER_HALF_CYC
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic [tor_pkg::OUT_W-1:0] sample_i,
  input  wire logic [tor_pkg::OUT_W-1:0] sample_q,
  input  wire logic                      sample_valid,
  output logic                           sample_ready,
  input  wire logic                      sampler_offset_clk,
  input  wire logic                      sampler_offset_data,
  input  wire logic                      sampler_offset_word_sync,
  input  wire logic                      inphase_bus_enable_n,
  input  wire logic                      quadrature_bus_enable_n,
  output logic [tor_pkg::OUT_W-1:0]      inphase_out_bus,
  output logic                           inphase_out_oe_n,
  output logic [tor_pkg::OUT_W-1:0]      quadrature_out_bus,
  output logic                           quadrature_out_oe_n,
  output logic                           output_valid_flag,
  output logic                           oscillator_test_point,
  output logic                           symbol_timing_strobe,
  output logic [tor_pkg::PH_W-1:0]       resample_phase_bits
);
  localparam int W = tor_pkg::OUT_W;
  localparam int N = tor_pkg::NCO_W;

  function automatic logic [tor_pkg::PH_W-1:0] phase_pick(input logic [N-1:0] acc, input logic [1:0] sel);
    logic [tor_pkg::PH_TOP-1:0] top;
    top = acc[N-1 -: tor_pkg::PH_TOP];
    phase_pick = top[(tor_pkg::PH_TOP-1-32'(sel)) -: tor_pkg::PH_W];
  endfunction : phase_pick

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        old[8*b +: 8] = nw[8*b +: 8];
      end
    end
    strb_merge = old;
  endfunction : strb_merge

  logic [31:0]    ctrl_q;
  logic [31:0]    syn_freq_q;
  logic [31:0]    smp_freq_q;
  logic [OFS_W-1:0] ofs_word_q;
  logic           bvalid_q;
  logic [1:0]     bresp_q;
  logic           rvalid_q;
  logic [1:0]     rresp_q;
  logic [31:0]    rdata_q;
  logic           wr_go;
  logic           rd_go;
  logic           serial;
  logic           sampled;
  logic           vpol;
  logic           idle_lvl;
  logic [1:0]     psel;

  assign serial   = ctrl_q[tor_pkg::CTRL_SERIAL];
  assign sampled  = ctrl_q[tor_pkg::CTRL_SAMPLED];
  assign vpol     = ctrl_q[tor_pkg::CTRL_VPOL];
  assign idle_lvl = ctrl_q[tor_pkg::CTRL_IDLE_LVL];
  assign psel     = ctrl_q[tor_pkg::CTRL_PSEL_LSB +: 2];

  // Address and data are taken together; a held response blocks the next write.
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign rd_go         = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q     <= tor_pkg::CTRL_RST;
      syn_freq_q <= tor_pkg::FREQ_RST;
      smp_freq_q <= tor_pkg::FREQ_RST;
      bvalid_q   <= 1'b0;
      bresp_q    <= tor_pkg::RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q  <= tor_pkg::RESP_OKAY;
        unique case (s_axi_awaddr)
          tor_pkg::REG_CTRL:     ctrl_q     <= strb_merge(ctrl_q, s_axi_wdata, s_axi_wstrb);
          tor_pkg::REG_SYN_FREQ: syn_freq_q <= strb_merge(syn_freq_q, s_axi_wdata, s_axi_wstrb);
          tor_pkg::REG_SMP_FREQ: smp_freq_q <= strb_merge(smp_freq_q, s_axi_wdata, s_axi_wstrb);
          tor_pkg::REG_OFS_WORD, tor_pkg::REG_STATUS: bresp_q <= tor_pkg::RESP_OKAY;
          default:               bresp_q    <= tor_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Sampler offset link: all three pins are resynchronised before use.
  logic [2:0] lk_s1_q;
  logic [2:0] lk_s2_q;
  logic       lk_clk_d1_q;
  logic       lk_tick;
  logic       ofs_busy_q;
  logic [$clog2(OFS_W)-1:0] ofs_cnt_q;
  logic [OFS_W-1:0] ofs_sh_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lk_s1_q     <= '0;
      lk_s2_q     <= '0;
      lk_clk_d1_q <= 1'b0;
    end else begin
      lk_s1_q     <= {sampler_offset_clk, sampler_offset_data, sampler_offset_word_sync};
      lk_s2_q     <= lk_s1_q;
      lk_clk_d1_q <= lk_s2_q[2];
    end
  end
  assign lk_tick = lk_s2_q[2] && !lk_clk_d1_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ofs_busy_q <= 1'b0;
      ofs_cnt_q  <= '0;
      ofs_sh_q   <= '0;
      ofs_word_q <= '0;
    end else if (lk_tick) begin
      if (lk_s2_q[0]) begin
        ofs_busy_q <= 1'b1;
        ofs_cnt_q  <= '0;
      end else if (ofs_busy_q) begin
        ofs_sh_q  <= {ofs_sh_q[OFS_W-2:0], lk_s2_q[1]};
        ofs_cnt_q <= ofs_cnt_q + 1'b1;
        if (ofs_cnt_q == ($clog2(OFS_W))'(OFS_W-1)) begin
          ofs_busy_q <= 1'b0;
          ofs_word_q <= {ofs_sh_q[OFS_W-2:0], lk_s2_q[1]};
        end
      end
    end
  end

  // Both oscillators advance once per clock.
  logic [N-1:0] syn_acc_q;
  logic [N-1:0] smp_acc_q;
  logic [N:0]   smp_sum;
  logic         carry_q;
  logic         tp_q;

  assign smp_sum = {1'b0, smp_acc_q} + {1'b0, smp_freq_q} + {1'b0, N'(ofs_word_q)};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      syn_acc_q <= '0;
      smp_acc_q <= '0;
      carry_q   <= 1'b0;
      tp_q      <= 1'b0;
    end else begin
      syn_acc_q <= syn_acc_q + syn_freq_q;
      smp_acc_q <= smp_sum[N-1:0];
      carry_q   <= smp_sum[N];
      tp_q      <= syn_acc_q[N-1];
    end
  end
  assign oscillator_test_point = tp_q;

  // Output path: a FIFO absorbs samples while the serial formatter is busy.
  logic               fifo_valid;
  logic               pop;
  logic [2*W-1:0]     fifo_data;
  logic [$clog2(tor_pkg::FIFO_DEPTH):0] fifo_level;

  tor_fifo #(.WIDTH(2*W), .DEPTH(tor_pkg::FIFO_DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   ({sample_i, sample_q}),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data),
    .level     (fifo_level)
  );

  tor_pkg::tor_ser_e st_q;
  logic [$clog2(SER_HALF+1)-1:0] div_q;
  logic           tick;
  logic           half_q;
  logic           bit_end;
  logic [3:0]     bit_cnt_q;
  logic [W-1:0]   sh_i_q;
  logic [W-1:0]   sh_q_q;
  logic           sbit_i_q;
  logic           sbit_q_q;

  assign pop     = fifo_valid && (st_q == tor_pkg::SER_IDLE);
  assign tick    = div_q == ($clog2(SER_HALF+1))'(SER_HALF-1);
  assign bit_end = tick && half_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q      <= tor_pkg::SER_IDLE;
      div_q     <= '0;
      half_q    <= 1'b0;
      bit_cnt_q <= '0;
      sh_i_q    <= '0;
      sh_q_q    <= '0;
      sbit_i_q  <= 1'b0;
      sbit_q_q  <= 1'b0;
    end else begin
      div_q <= (tick || st_q == tor_pkg::SER_IDLE) ? '0 : div_q + 1'b1;
      if (tick) begin
        half_q <= !half_q;
      end
      unique case (st_q)
        tor_pkg::SER_IDLE: begin
          half_q <= 1'b0;
          if (pop && serial) begin
            st_q   <= tor_pkg::SER_LEAD;
            sh_i_q <= fifo_data[2*W-1:W];
            sh_q_q <= fifo_data[W-1:0];
          end
        end
        tor_pkg::SER_LEAD, tor_pkg::SER_SHIFT: begin
          if (bit_end) begin
            sbit_i_q <= sh_i_q[W-1];
            sbit_q_q <= sh_q_q[W-1];
            sh_i_q   <= {sh_i_q[W-2:0], 1'b0};
            sh_q_q   <= {sh_q_q[W-2:0], 1'b0};
            if (st_q == tor_pkg::SER_LEAD) begin
              st_q      <= tor_pkg::SER_SHIFT;
              bit_cnt_q <= '0;
            end else if (bit_cnt_q == 4'(W-1)) begin
              st_q <= tor_pkg::SER_IDLE;
            end else begin
              bit_cnt_q <= bit_cnt_q + 1'b1;
            end
          end
        end
        default: st_q <= tor_pkg::SER_IDLE;
      endcase
    end
  end

  logic [W-1:0] out_i_q;
  logic [W-1:0] out_q_q;
  logic         flag_q;
  logic         strobe_q;
  logic         strobe_d;
  logic         pend_q;
  logic [tor_pkg::PH_W-1:0] ph_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_i_q <= '0;
      out_q_q <= '0;
      flag_q  <= 1'b0;
    end else begin
      flag_q <= pop ^ !vpol;
      if (serial) begin
        out_i_q <= {half_q, {(W-2){idle_lvl}}, sbit_i_q};
        out_q_q <= {{(W-1){idle_lvl}}, sbit_q_q};
      end else if (pop) begin
        out_i_q <= fifo_data[2*W-1:W];
        out_q_q <= fifo_data[W-1:0];
      end
    end
  end

  // A boundary is held pending until the next sample leaves; a carry that meets the strobe is served by it.
  assign strobe_d = pop && (pend_q || carry_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q   <= 1'b0;
      strobe_q <= 1'b0;
      ph_q     <= '0;
    end else begin
      pend_q <= (carry_q || pend_q) && !strobe_d;
      if (sampled) begin
        strobe_q <= strobe_d;
        if (strobe_d) begin
          ph_q <= phase_pick(smp_acc_q, psel);
        end
      end else begin
        strobe_q <= carry_q;
        ph_q     <= phase_pick(smp_acc_q, psel);
      end
    end
  end

  assign inphase_out_bus       = out_i_q;
  assign quadrature_out_bus    = out_q_q;
  assign inphase_out_oe_n      = inphase_bus_enable_n;
  assign quadrature_out_oe_n   = quadrature_bus_enable_n;
  assign output_valid_flag     = flag_q;
  assign symbol_timing_strobe  = strobe_q;
  assign resample_phase_bits   = ph_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= tor_pkg::RESP_OKAY;
      rdata_q  <= '0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= tor_pkg::RESP_OKAY;
      rdata_q  <= '0;
      unique case (s_axi_araddr)
        tor_pkg::REG_CTRL:     rdata_q <= ctrl_q;
        tor_pkg::REG_SYN_FREQ: rdata_q <= syn_freq_q;
        tor_pkg::REG_SMP_FREQ: rdata_q <= smp_freq_q;
        tor_pkg::REG_OFS_WORD: rdata_q <= 32'(ofs_word_q);
        tor_pkg::REG_STATUS: begin
          rdata_q[tor_pkg::STAT_LVL_LSB +: 5] <= 5'(fifo_level);
          rdata_q[tor_pkg::STAT_PEND]         <= pend_q;
          rdata_q[tor_pkg::STAT_BUSY]         <= ofs_busy_q;
          rdata_q[tor_pkg::STAT_ST_LSB +: 2]  <= st_q;
        end
        default:               rresp_q <= tor_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_lead_done;
    (st_q == tor_pkg::SER_LEAD) && bit_end;
  endsequence
  sequence s_first_bit;
    (st_q == tor_pkg::SER_SHIFT) && (sbit_i_q == $past(sh_i_q[W-1]));
  endsequence

  a_ofs_sync_start: assert property (lk_tick && lk_s2_q[0] |=> ofs_busy_q && ofs_cnt_q == '0)
    else $error("offset shift did not start after sync");
  a_par_bus_load: assert property (pop && !serial |=> out_i_q == $past(fifo_data[2*W-1:W])
    && out_q_q == $past(fifo_data[W-1:0]))
    else $error("parallel bus does not hold popped sample");
  a_ser_idle_pins: assert property (serial && $past(serial) |-> out_q_q[W-1:1] == {(W-1){$past(idle_lvl)}})
    else $error("unused serial pins not at idle level");
  a_valid_flag_level: assert property (pop |=> output_valid_flag == $past(vpol))
    else $error("valid flag not active with new data");
  a_ser_lead_bit: assert property (s_lead_done |=> s_first_bit)
    else $error("first serial bit not after lead bit period");
  a_test_point: assert property (##1 oscillator_test_point == $past(syn_acc_q[N-1]))
    else $error("test point is not accumulator MSB");
  a_cont_strobe: assert property (!sampled && $past(!sampled) |-> symbol_timing_strobe == $past(carry_q))
    else $error("continuous strobe differs from carry");
  a_sampled_hold: assert property (sampled && !strobe_d |=> $stable(resample_phase_bits))
    else $error("phase bits moved without strobe");
  a_strobe_pulse: assert property (sampled && strobe_d |=> symbol_timing_strobe && output_valid_flag == vpol
    ##1 !symbol_timing_strobe || !sampled)
    else $error("sampled strobe not a single pulse with flag");
  a_phase_source: assert property (!sampled |=> resample_phase_bits == phase_pick($past(smp_acc_q), $past(psel)))
    else $error("phase bits not taken from accumulator top");
endmodule : tor_top
`default_nettype wire

// ===== verif/tor_ofs_loop.sv
`timescale 1ns/1ps
`default_nettype none
module tor_ofs_loop (
  output logic link_clk,
  output logic link_data,
  output logic link_sync
);
  initial begin
    link_clk  = 1'b0;
    link_data = 1'b0;
    link_sync = 1'b0;
  end

  // The link clock only runs inside a frame, and an idle data line never keeps its last bit.
  task automatic send(input logic [31:0] w);
    link_sync = 1'b1;
    link_data = ~link_data;
    #40 link_clk = 1'b1;
    for (int k = 31; k >= 0; k--) begin
      #40 link_clk = 1'b0;
      link_sync = 1'b0;
      link_data = w[k];
      #40 link_clk = 1'b1;
    end
    #40 link_clk = 1'b0;
    link_data = ~link_data;
  endtask : send
endmodule : tor_ofs_loop
`default_nettype wire

// ===== verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SH = tor_pkg::SER_HALF_CYC;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sv, sr, lclk, ldat, lsync;
  logic        en_i, en_q, oe_i, oe_q, flag, tp, strb, vpol, par_mon, smp_mon, saw_full;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, w;
  logic [1:0]  bresp, rresp, resp;
  logic [9:0]  si, sq, ib, qb;
  logic [4:0]  ph, ph_prev;
  logic [19:0] exp_q[$];
  int          fail_count, num_checks, seed, seed_en, n_strb;

  tor_top i_tor_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sample_i(si), .sample_q(sq),
    .sample_valid(sv), .sample_ready(sr), .sampler_offset_clk(lclk), .sampler_offset_data(ldat),
    .sampler_offset_word_sync(lsync), .inphase_bus_enable_n(en_i), .quadrature_bus_enable_n(en_q),
    .inphase_out_bus(ib), .inphase_out_oe_n(oe_i), .quadrature_out_bus(qb), .quadrature_out_oe_n(oe_q),
    .output_valid_flag(flag), .oscillator_test_point(tp), .symbol_timing_strobe(strb),
    .resample_phase_bits(ph));
  tor_ofs_loop i_tor_ofs_loop (.link_clk(lclk), .link_data(ldat), .link_sync(lsync));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic give_up();
    check(32'h0, 32'h1);
    final_report();
  endtask : give_up

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        r = bresp;
        done = 1'b1;
      end
    end
    if (!done) give_up();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 200 && !done; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
    if (!done) give_up();
  endtask : axi_read

  // Pushes random words, sometimes back to back, sometimes with a gap; records a refusal seen.
  task automatic push(input int cnt);
    logic [9:0] a, b;
    int         n;
    @(posedge aclk);
    for (int k = 0; k < cnt; k++) begin
      a = 10'($random(seed));
      b = 10'($random(seed));
      si <= a;
      sq <= b;
      sv <= 1'b1;
      n = 0;
      do begin
        @(posedge aclk);
        n++;
        if (sr !== 1'b1) saw_full = 1'b1;
      end while (sr !== 1'b1 && n < 2000);
      if (n >= 2000) give_up();
      exp_q.push_back({a, b});
      if ($random(seed) & 1) begin
        sv <= 1'b0;
        @(posedge aclk);
      end
    end
    sv <= 1'b0;
  endtask : push

  task automatic ser_word();
    logic [19:0] e;
    int          n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (flag !== 1'b1 && n < 500);
    if (n >= 500) give_up();
    e = exp_q.pop_front();
    repeat (2 * SH + 1) @(posedge aclk);
    for (int k = 9; k >= 0; k--) begin
      check({ib[9], ib[8:1], qb[9:1]}, {1'b0, 17'h1ffff});
      repeat (SH) @(posedge aclk);
      check({ib[9], ib[0], qb[0]}, {1'b1, e[10+k], e[k]});
      if (k > 0) repeat (SH) @(posedge aclk);
    end
  endtask : ser_word

  always @(posedge aclk) begin
    en_i <= 1'($random(seed_en));
    en_q <= 1'($random(seed_en));
    if (par_mon && flag === vpol) check({ib, qb}, exp_q.size() > 0 ? exp_q.pop_front() : 20'hfffff);
    if (smp_mon && strb === 1'b1) begin
      n_strb++;
      check(flag, vpol);
      check(ph < 5'd8, 1'b1);
    end else if (smp_mon) check(ph, ph_prev);
    ph_prev = ph;
  end

  always @(negedge aclk) if (aresetn === 1'b1) check({oe_i, oe_q}, {en_i, en_q});

  initial begin
    logic [4:0] p;
    logic       t;
    int         cnt;
    seed = 32'hf130c8b5;
    seed_en = seed ^ 32'h5a5a5a5a;
    {awvalid, wvalid, bready, arvalid, rready, sv, en_i, en_q} = 8'h0;
    {par_mon, smp_mon, saw_full, vpol} = 4'h1;
    {awaddr, araddr, wdata, si, sq} = '0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(tor_pkg::REG_CTRL, rd, resp);
    check(rd, tor_pkg::CTRL_RST);
    axi_read(8'h40, rd, resp);
    check({rd[29:0], resp}, {30'h0, tor_pkg::RESP_SLVERR});
    axi_write(8'h40, 32'h1, resp);
    check(resp, tor_pkg::RESP_SLVERR);
    w = $random(seed);
    i_tor_ofs_loop.send(w);
    repeat (10) @(posedge aclk);
    axi_write(tor_pkg::REG_OFS_WORD, ~w, resp);
    axi_read(tor_pkg::REG_OFS_WORD, rd, resp);
    check(rd, w);
    i_tor_ofs_loop.send(32'h0);
    repeat (10) @(posedge aclk);
    axi_write(tor_pkg::REG_SYN_FREQ, 32'h80000000, resp);
    for (int s = 0; s < 4; s++) begin
      axi_write(tor_pkg::REG_CTRL, 32'h2 | (s << 3), resp);
      axi_write(tor_pkg::REG_SMP_FREQ, 32'h1 << (27 - s), resp);
      repeat (8) @(posedge aclk);
      p = ph;
      t = tp;
      cnt = 0;
      for (int c = 0; c < 256; c++) begin
        @(posedge aclk);
        check({tp, ph}, {~t, p + 5'h1});
        cnt += (strb === 1'b1);
        p = ph;
        t = tp;
      end
      check(cnt, 256 >> (5 + s));
    end
    par_mon = 1'b1;
    push(40);
    repeat (10) @(posedge aclk);
    check(exp_q.size(), 0);
    par_mon = 1'b0;
    axi_write(tor_pkg::REG_CTRL, 32'h0, resp);
    vpol = 1'b0;
    // The flag keeps the old polarity for one cycle after the control write.
    repeat (2) @(posedge aclk);
    par_mon = 1'b1;
    push(30);
    repeat (10) @(posedge aclk);
    check(exp_q.size(), 0);
    par_mon = 1'b0;
    axi_write(tor_pkg::REG_CTRL, 32'h6, resp);
    axi_write(tor_pkg::REG_SMP_FREQ, 32'h08000000, resp);
    vpol = 1'b1;
    repeat (4) @(posedge aclk);
    // One sample first flushes a boundary left pending from continuous mode.
    {par_mon, smp_mon, n_strb} = {2'b10, 32'h0};
    push(1);
    repeat (3) @(posedge aclk);
    smp_mon = 1'b1;
    push(149);
    repeat (10) @(posedge aclk);
    smp_mon = 1'b0;
    check(n_strb >= 4, 1'b1);
    check(exp_q.size(), 0);
    par_mon = 1'b0;
    axi_write(tor_pkg::REG_CTRL, 32'h23, resp);
    saw_full = 1'b0;
    fork
      push(18);
      begin
        ser_word();
        ser_word();
      end
    join
    repeat (900) @(posedge aclk);
    check(saw_full, 1'b1);
    axi_read(tor_pkg::REG_STATUS, rd, resp);
    check({rd[9], rd[4:0]}, 6'h0);
    final_report();
  end
endmodule : testbench
`default_nettype wire
